//--- verilog/fcl_pkg.sv
// fcl_pkg: constants and helpers shared by both ends of the parallel config link
package fcl_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int T_CFG_US        = 2;
  localparam int T_CFG_CYC       = T_CFG_US * CLK_MHZ;
  localparam int T_STAT_MIN_US   = 268;
  localparam int T_STAT_MIN_CYC  = T_STAT_MIN_US * CLK_MHZ;
  localparam int T_CF2CK_US      = 1506;
  localparam int T_CF2CK_CYC     = T_CF2CK_US * CLK_MHZ;
  localparam int T_ST2CK_US      = 2;
  localparam int T_ST2CK_CYC     = T_ST2CK_US * CLK_MHZ;
  localparam int T_INIT_MIN_US   = 175;
  localparam int T_INIT_MIN_CYC  = T_INIT_MIN_US * CLK_MHZ;
  localparam int T_CCLK_MAX_NS   = 10;
  localparam int UCLK_EN_PER     = 4;
  localparam int UCLK_EN_CYC     = (UCLK_EN_PER * T_CCLK_MAX_NS * CLK_MHZ + 999) / 1000;
  localparam int UINIT_EDGES     = 8576;
  localparam int CCLK_DIV        = 2;
  localparam int UCLK_DIV        = 2;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int WW = 16;
  localparam int TW = 18;
  localparam int UW = 14;
  // ---------------------------------------------------------------
  // host register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_WORDS = 8'h04;
  localparam logic [7:0] ADDR_DATA  = 8'h08;
  localparam logic [7:0] ADDR_STAT  = 8'h0C;
  localparam int CTL_GO     = 0;
  localparam int CTL_WIDE   = 1;
  localparam int CTL_DECOMP = 2;
  localparam int CTL_SECURE = 3;
  localparam int CTL_UCLK   = 4;
  localparam int CTL_MON    = 5;
  localparam logic [5:1] CTL_RESET = 5'h00;
  localparam int ST_BUSY    = 0;
  localparam int ST_STATUS  = 1;
  localparam int ST_DONE    = 2;
  localparam int ST_FULL    = 3;
  localparam int ST_STATE   = 4;
  localparam int ST_SENT    = 16;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] fcl_ratio(input logic wide, input logic decomp, input logic secure);
    if (!wide)
      fcl_ratio = decomp ? 3'h2 : 3'h1;
    else if (decomp)
      fcl_ratio = 3'h4;
    else
      fcl_ratio = secure ? 3'h2 : 3'h1;
  endfunction : fcl_ratio
  function automatic logic [WW-1:0] fcl_bin2gray(input logic [WW-1:0] b);
    fcl_bin2gray = b ^ (b >> 1);
  endfunction : fcl_bin2gray
  function automatic logic [WW-1:0] fcl_gray2bin(input logic [WW-1:0] g);
    logic [WW-1:0] b;
    b = g;
    for (int i = WW - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    fcl_gray2bin = b;
  endfunction : fcl_gray2bin
endpackage : fcl_pkg

//--- verilog/fcl_link_if.sv
// fcl_link_if: configuration pins between host and device, open-drain lines resolved here
`timescale 1ns/1ns
`default_nettype none
interface fcl_link_if;
  logic          reconfig_start_n;
  logic          status_o;
  logic          status_oe;
  logic          done_o;
  logic          done_oe;
  logic          config_clock;
  logic [15:0]   config_word;
  logic          user_init_clock;
  wire logic     cfg_status_n;
  wire logic     load_complete;
  // pulled-up open-drain lines
  assign cfg_status_n  = ~(status_oe & ~status_o);
  assign load_complete = ~(done_oe & ~done_o);
  modport dev (
    input  reconfig_start_n, config_clock, config_word, user_init_clock, cfg_status_n, load_complete,
    output status_o, status_oe, done_o, done_oe
  );
  modport host (
    output reconfig_start_n, config_clock, config_word, user_init_clock,
    input  cfg_status_n, load_complete
  );
endinterface : fcl_link_if
`default_nettype wire

//--- verilog/fcl_device.sv
// fcl_device: configuration-load end of the programmable device
`timescale 1ns/1ns
`default_nettype none
module fcl_device
  import fcl_pkg::*;
#(
  parameter int STAT_MIN_CYC  = T_STAT_MIN_CYC,
  parameter int INIT_MIN_CYC  = T_INIT_MIN_CYC,
  parameter int UINIT_EDGES_P = UINIT_EDGES
)(
  // system
  input  wire logic          clk,
  input  wire logic          rstn,
  // link
  fcl_link_if.dev            lnk,
  // load options
  input  wire logic          opt_wide,
  input  wire logic          opt_decomp,
  input  wire logic          opt_secure,
  input  wire logic          opt_user_clk,
  input  wire logic [WW-1:0] load_words,
  // user side
  output logic               user_mode,
  output logic [WW-1:0]      cap_word,
  output logic               cap_valid
);
  typedef enum logic [1:0] {
    D_HOLD = 2'b00,
    D_LOAD = 2'b01,
    D_INIT = 2'b11,
    D_USER = 2'b10
  } fcl_dstate_e;
  fcl_dstate_e    state_r, state_nxt;
  logic [TW-1:0]  tmr_r, tmr_nxt;
  logic [UW-1:0]  ucnt_r, ucnt_nxt;
  logic [WW-1:0]  base_r, base_nxt;
  logic           st_s1, st_s2;
  logic           ui_s1, ui_s2, ui_s3;
  logic [WW-1:0]  gy_s1, gy_s2;
  logic [2:0]     ratio_r;
  logic           status_oe_r, done_oe_r, user_r;
  logic           wide_r;
  logic [2:0]     phase_r;
  logic [WW-1:0]  wcnt_r, wgray_r, cap_word_r;
  logic           cap_valid_r;
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic [WW-1:0] wcnt_bin = fcl_gray2bin(gy_s2);
  wire logic [WW-1:0] got_w    = wcnt_bin - base_r;
  wire logic          loaded   = (got_w == load_words);
  wire logic          stat_hit = (tmr_r == TW'(STAT_MIN_CYC - 1));
  wire logic          init_hit = (tmr_r == TW'(INIT_MIN_CYC - 1));
  wire logic          uen      = (tmr_r >= TW'(UCLK_EN_CYC));
  wire logic          uedge    = ui_s2 & ~ui_s3;
  wire logic          ulast    = (ucnt_r == UW'(UINIT_EDGES_P - 1));
  assign lnk.status_o  = 1'b0;
  assign lnk.done_o    = 1'b0;
  assign lnk.status_oe = status_oe_r;
  assign lnk.done_oe   = done_oe_r;
  assign user_mode     = user_r;
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r;
    ucnt_nxt  = ucnt_r;
    base_nxt  = base_r;
    case (state_r)
      D_HOLD:
      begin
        if (stat_hit)
        begin
          state_nxt = D_LOAD;
          base_nxt  = wcnt_bin;
        end
        else
          tmr_nxt = tmr_r + 1'b1;
      end
      D_LOAD:
      begin
        if (loaded)
        begin
          state_nxt = D_INIT;
          tmr_nxt   = '0;
          ucnt_nxt  = '0;
        end
      end
      D_INIT:
      begin
        if (!opt_user_clk)
        begin
          if (init_hit)
            state_nxt = D_USER;
          else
            tmr_nxt = tmr_r + 1'b1;
        end
        else if (!uen)
          tmr_nxt = tmr_r + 1'b1;
        else if (uedge)
        begin
          if (ulast)
            state_nxt = D_USER;
          else
            ucnt_nxt = ucnt_r + 1'b1;
        end
      end
      D_USER: ;
      default: state_nxt = D_HOLD;
    endcase
    if (!st_s2)
    begin
      state_nxt = D_HOLD;
      tmr_nxt   = '0;
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_s1 <= 1'b0; st_s2 <= 1'b0;
      ui_s1 <= 1'b0; ui_s2 <= 1'b0; ui_s3 <= 1'b0;
      gy_s1 <= '0;   gy_s2 <= '0;
      state_r <= D_HOLD; tmr_r <= '0; ucnt_r <= '0; base_r <= '0;
      status_oe_r <= 1'b1; done_oe_r <= 1'b1; user_r <= 1'b0;
      ratio_r <= 3'h1;
    end
    else
    begin
      st_s1 <= lnk.reconfig_start_n; st_s2 <= st_s1;
      ui_s1 <= lnk.user_init_clock;  ui_s2 <= ui_s1; ui_s3 <= ui_s2;
      gy_s1 <= wgray_r; gy_s2 <= gy_s1;
      state_r <= state_nxt; tmr_r <= tmr_nxt; ucnt_r <= ucnt_nxt; base_r <= base_nxt;
      status_oe_r <= (state_nxt == D_HOLD);
      done_oe_r   <= (state_nxt == D_HOLD) || (state_nxt == D_LOAD);
      user_r      <= (state_nxt == D_USER);
      ratio_r     <= fcl_ratio(opt_wide, opt_decomp, opt_secure);
    end
  end
  // ---------------------------------------------------------------
  // word capture on the link clock
  // ---------------------------------------------------------------
  // link clock stops between loads, so a synchroniser on it
  // would lag the first edges of a load; ratio and width only
  // change while idle, long before the first link edge, and
  // are read here as static levels
  wire logic [WW-1:0] wcnt_inc  = wcnt_r + 1'b1;
  wire logic          take      = (phase_r == 3'h0);
  wire logic          phase_end = (phase_r >= ratio_r - 3'h1);
  assign cap_word  = cap_word_r;
  assign cap_valid = cap_valid_r;
  always_ff @(posedge lnk.config_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_r     <= 3'h0;
      wcnt_r      <= '0;
      wgray_r     <= '0;
      cap_word_r  <= '0;
      cap_valid_r <= 1'b0;
    end
    else
    begin
      phase_r     <= phase_end ? 3'h0 : phase_r + 3'h1;
      cap_valid_r <= take;
      if (take)
      begin
        cap_word_r <= wide_r ? lnk.config_word : {8'h00, lnk.config_word[7:0]};
        wcnt_r     <= wcnt_inc;
        wgray_r    <= fcl_bin2gray(wcnt_inc);
      end
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wide_r <= 1'b0;
    else
      wide_r <= opt_wide;
  end
endmodule : fcl_device
`default_nettype wire

//--- verilog/fcl_host.sv
// fcl_host: APB-controlled host that drives a parallel configuration load
`timescale 1ns/1ns
`default_nettype none
module fcl_host
  import fcl_pkg::*;
#(
  parameter int CF2CK_CYC = T_CF2CK_CYC
)(
  // system
  input  wire logic        clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  fcl_link_if.host         lnk
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_PULSE = 3'b001,
    H_WAIT  = 3'b011,
    H_LOAD  = 3'b010,
    H_DONE  = 3'b110
  } fcl_hstate_e;
  fcl_hstate_e    state_r, state_nxt;
  logic [TW-1:0]  tmr_r, tmr_nxt;
  logic [5:1]     ctl_r;
  logic [WW-1:0]  words_r, word_r, sent_r, sent_nxt, wout_r, wout_nxt;
  logic           full_r, full_nxt;
  logic           cclk_r, cclk_nxt;
  logic           div_r, div_nxt;
  logic [2:0]     hph_r, hph_nxt;
  logic           have_r, have_nxt;
  logic           ucen_r, ucen_nxt;
  logic           udiv_r, uclk_r;
  logic           rst_n_r;
  logic           st_s1, st_s2, lc_s1, lc_s2;
  logic [31:0]    prdata_r;
  logic           pready_r, pslverr_r;
  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire logic sel_ctrl  = (paddr == ADDR_CTRL);
  wire logic sel_words = (paddr == ADDR_WORDS);
  wire logic sel_data  = (paddr == ADDR_DATA);
  wire logic sel_stat  = (paddr == ADDR_STAT);
  wire logic mapped    = sel_ctrl | sel_words | sel_data | sel_stat;
  wire logic acc_w     = psel & penable & ~pready_r;
  wire logic stall_w   = acc_w & pwrite & sel_data & full_r;
  wire logic ok_w      = acc_w & ~stall_w;
  wire logic wr_w      = ok_w & pwrite;
  wire logic go_w      = wr_w & sel_ctrl & pwdata[CTL_GO] & (state_r == H_IDLE);
  wire logic [31:0] stat_w = {sent_r, 9'h000, state_r, full_r, lc_s2, st_s2, (state_r != H_IDLE)};
  wire logic [31:0] rdata_w =
    sel_ctrl  ? {26'h0000000, ctl_r, 1'b0} :
    sel_words ? {16'h0000, words_r} :
    sel_stat  ? stat_w : 32'h00000000;
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  // ---------------------------------------------------------------
  // load decode
  // ---------------------------------------------------------------
  wire logic [2:0] ratio_w = fcl_ratio(ctl_r[CTL_WIDE], ctl_r[CTL_DECOMP], ctl_r[CTL_SECURE]);
  wire logic       tick    = (div_r == 1'(CCLK_DIV - 1));
  wire logic       all_out = (sent_r == words_r);
  wire logic       ph_wrap = (hph_r >= ratio_w - 3'h1);
  assign lnk.reconfig_start_n = rst_n_r;
  assign lnk.config_clock     = cclk_r;
  assign lnk.config_word      = wout_r;
  assign lnk.user_init_clock  = uclk_r;
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r;
    sent_nxt  = sent_r;
    wout_nxt  = wout_r;
    full_nxt  = full_r;
    cclk_nxt  = cclk_r;
    div_nxt   = 1'b0;
    hph_nxt   = hph_r;
    have_nxt  = have_r;
    ucen_nxt  = ucen_r;
    if (wr_w && sel_data)
      full_nxt = 1'b1;
    case (state_r)
      H_IDLE:
      begin
        if (go_w)
        begin
          state_nxt = H_PULSE;
          tmr_nxt   = '0;
          sent_nxt  = '0;
          ucen_nxt  = 1'b0;
        end
      end
      H_PULSE:
      begin
        if (tmr_r == TW'(T_CFG_CYC - 1))
        begin
          state_nxt = H_WAIT;
          tmr_nxt   = '0;
        end
        else
          tmr_nxt = tmr_r + 1'b1;
      end
      H_WAIT:
      begin
        if (ctl_r[CTL_MON] && !st_s2)
          tmr_nxt = '0;
        else if ((ctl_r[CTL_MON] && tmr_r == TW'(T_ST2CK_CYC - 1)) ||
                 (!ctl_r[CTL_MON] && tmr_r == TW'(CF2CK_CYC - 1)))
        begin
          state_nxt = H_LOAD;
          hph_nxt   = 3'h0;
          have_nxt  = 1'b0;
          cclk_nxt  = 1'b0;
        end
        else
          tmr_nxt = tmr_r + 1'b1;
      end
      H_LOAD:
      begin
        div_nxt = tick ? 1'b0 : 1'b1;
        if (tick)
        begin
          if (cclk_r)
            cclk_nxt = 1'b0;
          else if (hph_r == 3'h0 && !have_r)
          begin
            if (all_out)
            begin
              state_nxt = H_DONE;
              tmr_nxt   = '0;
            end
            else if (full_r)
            begin
              wout_nxt = word_r;
              full_nxt = 1'b0;
              sent_nxt = sent_r + 1'b1;
              have_nxt = 1'b1;
            end
          end
          else
          begin
            cclk_nxt = 1'b1;
            hph_nxt  = ph_wrap ? 3'h0 : hph_r + 3'h1;
            have_nxt = 1'b0;
          end
        end
      end
      H_DONE:
      begin
        if (!lc_s2)
          tmr_nxt = '0;
        else if (tmr_r == TW'(UCLK_EN_CYC - 1))
        begin
          state_nxt = H_IDLE;
          ucen_nxt  = ctl_r[CTL_UCLK];
        end
        else
          tmr_nxt = tmr_r + 1'b1;
      end
      default: state_nxt = H_IDLE;
    endcase
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= H_IDLE; tmr_r <= '0; sent_r <= '0; wout_r <= '0; full_r <= 1'b0;
      cclk_r <= 1'b0; div_r <= 1'b0; hph_r <= 3'h0; have_r <= 1'b0; ucen_r <= 1'b0;
      rst_n_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt; tmr_r <= tmr_nxt; sent_r <= sent_nxt; wout_r <= wout_nxt;
      full_r <= full_nxt; cclk_r <= cclk_nxt; div_r <= div_nxt; hph_r <= hph_nxt;
      have_r <= have_nxt; ucen_r <= ucen_nxt;
      rst_n_r <= (state_nxt != H_PULSE);
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_s1 <= 1'b0; st_s2 <= 1'b0; lc_s1 <= 1'b0; lc_s2 <= 1'b0;
    end
    else
    begin
      st_s1 <= lnk.cfg_status_n;  st_s2 <= st_s1;
      lc_s1 <= lnk.load_complete; lc_s2 <= lc_s1;
    end
  end
  // user init clock divider, runs once enabled
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      udiv_r <= 1'b0; uclk_r <= 1'b0;
    end
    else if (ucen_r)
    begin
      udiv_r <= (udiv_r == 1'(UCLK_DIV - 1)) ? 1'b0 : 1'b1;
      if (udiv_r == 1'(UCLK_DIV - 1))
        uclk_r <= ~uclk_r;
    end
    else
    begin
      udiv_r <= 1'b0; uclk_r <= 1'b0;
    end
  end
  // apb slave registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_r <= CTL_RESET; words_r <= '0; word_r <= '0;
      prdata_r <= 32'h00000000; pready_r <= 1'b0; pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= ok_w;
      pslverr_r <= ok_w & ~mapped;
      if (ok_w && !pwrite)
        prdata_r <= rdata_w;
      if (wr_w && sel_ctrl)
        ctl_r <= pwdata[5:1];
      if (wr_w && sel_words)
        words_r <= pwdata[WW-1:0];
      if (wr_w && sel_data)
        word_r <= pwdata[WW-1:0];
    end
  end
endmodule : fcl_host
`default_nettype wire

//--- verilog/fcl_end.sv
// fcl_end: no logic of its own; both ends live in fcl_host and fcl_device
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- sim/fcl_link_monitor.sv
// fcl_link_monitor: timing checks on the link between host and device ends
`timescale 1ns/1ns
`default_nettype none
module fcl_link_monitor
  import fcl_pkg::*;
#(
  parameter int STAT_MIN_CYC = T_STAT_MIN_CYC,
  parameter int STAT_MAX_CYC = T_CF2CK_CYC,
  parameter int CF2CK_CYC    = T_CF2CK_CYC
)(
  // system
  input wire logic        clk,
  input wire logic        rstn,
  // link
  input wire logic        reconfig_start_n,
  input wire logic        cfg_status_n,
  input wire logic        load_complete,
  input wire logic        config_clock,
  input wire logic [15:0] config_word,
  input wire logic        user_init_clock
);
  localparam int FALL_MAX = 60;
  int lo_r, st_r, rel_r, sh_r, cf_r, dn_r;
  // ------------------------------------------------------------
  // duration counters
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      {lo_r, st_r, rel_r, sh_r, cf_r, dn_r} <= '0;
    else
    begin
      lo_r  <= reconfig_start_n ? 32'h0 : lo_r + 32'h1;
      st_r  <= cfg_status_n ? 32'h0 : st_r + 32'h1;
      rel_r <= (reconfig_start_n && !cfg_status_n) ? rel_r + 32'h1 : 32'h0;
      sh_r  <= cfg_status_n ? sh_r + 32'h1 : 32'h0;
      cf_r  <= reconfig_start_n ? cf_r + 32'h1 : 32'h0;
      dn_r  <= load_complete ? dn_r + 32'h1 : 32'h0;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_start_pulse_min: assert property ($rose(reconfig_start_n) |-> lo_r >= T_CFG_CYC)
    else $error("reconfig request pulse too short");
  a_status_fall_fast: assert property ($fell(reconfig_start_n) |-> ##[0:FALL_MAX] !cfg_status_n)
    else $error("status line not pulled low in time");
  a_done_fall_fast: assert property ($fell(reconfig_start_n) |-> ##[0:FALL_MAX] !load_complete)
    else $error("load complete not pulled low in time");
  a_status_hold_min: assert property ($rose(cfg_status_n) |-> st_r >= STAT_MIN_CYC)
    else $error("status low time too short");
  a_status_release_max: assert property (rel_r <= STAT_MAX_CYC)
    else $error("status not released in time");
  a_first_clock_wait: assert property ($rose(config_clock) |-> sh_r >= T_ST2CK_CYC || cf_r >= CF2CK_CYC)
    else $error("config clock started too early");
  a_no_clock_pulse: assert property (!reconfig_start_n |-> !$rose(config_clock))
    else $error("config clock rose during request pulse");
  a_clock_high_time: assert property ($rose(config_clock) |-> config_clock [*2] ##1 !config_clock)
    else $error("config clock high time wrong");
  a_word_change_low: assert property ($changed(config_word) |-> !config_clock)
    else $error("config word changed while clock high");
  a_user_clk_late: assert property ($rose(user_init_clock) |-> load_complete && dn_r >= UCLK_EN_CYC)
    else $error("user init clock started too early");
  c_load_done: cover property ($rose(load_complete));
  c_user_clk: cover property ($rose(user_init_clock));
  c_status_fall: cover property ($fell(reconfig_start_n) ##[1:FALL_MAX] !cfg_status_n);
endmodule : fcl_link_monitor
`default_nettype wire

//--- sim/fcl_config_load_tb_top.sv
// fcl_config_load_tb_top: host and device joined, host driven over apb, checked against a queue model
`timescale 1ns/1ns
`default_nettype none
module fcl_config_load_tb_top
  import fcl_pkg::*;
;
  localparam int STAT_MIN = 50;
  localparam int INIT_MIN = 40;
  localparam int UEDGES   = 16;
  localparam int CF2CK    = 300;
  localparam int UC_MIN   = UCLK_EN_CYC + UEDGES * 4;
  // {monitor, user clk, secure, decomp, wide}
  localparam logic [4:0] CFG_TAB [6] = '{5'h12, 5'h05, 5'h13, 5'h04, 5'h11, 5'h0F};
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        opt_wide, opt_decomp, opt_secure, opt_user_clk, user_mode, cap_valid;
  logic [15:0] load_words, cap_word;
  logic [31:0] exp_w [$];
  int          ratio, ph, miscompares, total_checks;
  fcl_link_if lnk ();
  fcl_host #(.CF2CK_CYC(CF2CK)) fcl_host_i (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  fcl_device #(.STAT_MIN_CYC(STAT_MIN), .INIT_MIN_CYC(INIT_MIN), .UINIT_EDGES_P(UEDGES)) fcl_device_i (
    .clk(clk), .rstn(rstn), .lnk(lnk), .opt_wide(opt_wide), .opt_decomp(opt_decomp),
    .opt_secure(opt_secure), .opt_user_clk(opt_user_clk), .load_words(load_words),
    .user_mode(user_mode), .cap_word(cap_word), .cap_valid(cap_valid));
  fcl_link_monitor #(.STAT_MIN_CYC(STAT_MIN), .STAT_MAX_CYC(STAT_MIN * 1506 / 268), .CF2CK_CYC(CF2CK))
    fcl_link_monitor_i (
    .clk(clk), .rstn(rstn), .reconfig_start_n(lnk.reconfig_start_n), .cfg_status_n(lnk.cfg_status_n),
    .load_complete(lnk.load_complete), .config_clock(lnk.config_clock), .config_word(lnk.config_word),
    .user_init_clock(lnk.user_init_clock));
  // ------------------------------------------------------------
  // clock, watchdog and helpers
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
      begin
        miscompares++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  function automatic int tb_ratio(input logic w, input logic d, input logic s);
    if (!w)
      return d ? 2 : 1;
    return d ? 4 : (s ? 2 : 1);
  endfunction : tb_ratio
  // ------------------------------------------------------------
  // link observers: word per edge, capture after edge
  // ------------------------------------------------------------
  always @(posedge lnk.config_clock)
  begin
    if (rstn === 1'b1)
      begin
        chk(lnk.config_word, exp_w[ph / ratio]);
        ph = ph + 1;
      end
  end
  always @(negedge lnk.config_clock)
  begin
    if (rstn === 1'b1)
      begin
        chk(cap_valid, ((ph - 1) % ratio) == 0);
        if (((ph - 1) % ratio) == 0)
          chk(cap_word, exp_w[(ph - 1) / ratio]);
      end
  end
  // ------------------------------------------------------------
  // one full load
  // ------------------------------------------------------------
  task automatic run_load(input logic [4:0] cfg);
    int          n;
    int          t;
    logic [31:0] rd;
    logic        err;
    n = 2 + ($urandom % 3);
    ratio = tb_ratio(cfg[0], cfg[1], cfg[2]);
    exp_w.delete();
    for (int i = 0; i < 8; i++)
      exp_w.push_back(cfg[0] ? ($urandom & 32'h0000FFFF) : ($urandom & 32'h000000FF));
    {opt_user_clk, opt_secure, opt_decomp, opt_wide} <= cfg[3:0];
    load_words <= n[15:0];
    ph = 0;
    repeat (4) @(posedge clk);
    apb(1'b1, ADDR_WORDS, n, rd, err);
    apb(1'b1, ADDR_CTRL, {26'h0, cfg, 1'b1}, rd, err);
    for (int i = 0; i < n; i++)
      apb(1'b1, ADDR_DATA, exp_w[i], rd, err);
    while (lnk.load_complete !== 1'b1)
      @(posedge clk);
    t = 0;
    while (user_mode !== 1'b1)
      begin
        @(posedge clk);
        t++;
      end
    // done rises after the last capture; its spare edges follow
    chk(ph, n * ratio);
    if (cfg[3])
      chk(t >= UC_MIN && t <= UC_MIN + 40, 1);
    else
      chk(t >= INIT_MIN - 1 && t <= INIT_MIN * 437 / 175, 1);
    apb(1'b0, ADDR_STAT, 32'h0, rd, err);
    chk(rd[31:16], n);
    chk(rd[6:4], 3'h0);
    chk(rd[0], 1'b0);
    chk(rd[2:1], 2'h3);
  endtask : run_load
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] rd;
    logic        err;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {opt_wide, opt_decomp, opt_secure, opt_user_clk, load_words} = '0;
    {rstn, ph, miscompares, total_checks} = '0;
    ratio = 1;
    void'($urandom(30));
    repeat (10) @(posedge clk);
    chk({lnk.cfg_status_n, lnk.load_complete, user_mode}, 3'h0);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h14, 32'hFFFFFFFF, rd, err);
    chk(err, 1'b1);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
    chk(rd[5:0], 6'h00);
    apb(1'b0, ADDR_STAT, 32'h0, rd, err);
    chk({rd[6:4], rd[0]}, 4'h0);
    for (int k = 0; k < 6; k++)
      run_load(CFG_TAB[k]);
    wrap_up();
  end
endmodule : fcl_config_load_tb_top
`default_nettype wire
